// *** src/wwdt_pkg.sv ***
// Purpose: shared constants for the windowed watchdog
// Assumes: 32-bit classic wishbone, byte addresses
// Notes:   one word per register, data in low byte except the 23-bit count
package wwdt_pkg;
  // register byte addresses
  localparam logic [3:0] ADR_CTRL0 = 4'h0;
  localparam logic [3:0] ADR_CTRL1 = 4'h4;
  localparam logic [3:0] ADR_STAT  = 4'h8;
  localparam logic [3:0] ADR_COUNT = 4'hC;
  // field positions
  localparam int C0_EN_BIT = 0;
  localparam int C0_PS_LSB = 1;
  localparam int C1_WN_LSB = 0;
  localparam int C1_CS_LSB = 4;
  localparam int ST_SPAN   = 0;
  localparam int ST_TMO    = 1;
  localparam int ST_PDN    = 2;
  // reset values and override codes
  localparam logic [4:0] PS_RESET  = 5'h0B;
  localparam logic [4:0] PS_SWSEL  = 5'h1F;
  localparam logic [4:0] PS_MAX    = 5'h12;
  localparam logic [2:0] CS_RESET  = 3'h0;
  localparam logic [2:0] CS_SWSEL  = 3'h7;
  localparam logic [2:0] CS_MID    = 3'h1;
  localparam logic [2:0] WN_RESET  = 3'h7;
  localparam logic [2:0] WN_SWSEL  = 3'h7;
  localparam logic [2:0] WN_FULL   = 3'h7;
  // operating modes
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_SW   = 2'h1;
  localparam logic [1:0] MODE_AWK  = 2'h2;
  localparam logic [1:0] MODE_ON   = 2'h3;
  // timing
  localparam int          PS_BASE_SH = 5;
  localparam int          EIGHTH_SH  = 2;
  localparam logic [3:0]  MID_DIV_TC = 4'hF;
  localparam int          CNT_W      = 23;
  typedef enum logic {WWDT_IDLE, WWDT_ACK} wwdt_bus_t;
endpackage

// *** src/wwdt_top.sv ***
// Purpose: windowed watchdog timer with wishbone registers
// Assumes: oscillator ticks are one-cycle pulses on MCLK
// Notes:   counter runs in time-base ticks, not MCLK cycles
// Functional notes
// [RL1] period elapsing without a clear requests a system reset
// [RL2] time base is low-freq osc or mid-freq osc divided by 16
// [RL3] four modes from a two-bit field; 00 keeps the dog off
// [RL4] mode 11 keeps the dog active always, sleep included
// [RL5] mode 10 is active awake and off in sleep
// [RL6] mode 01 follows the software enable, sleep ignored
// [RL7] prescale field sets the period from 1 ms to 256 s
// [RL8] period defaults to two seconds after reset
// [RL9] windowed clear outside the window resets like a time-out
// [RL10] window from config field, or from control 1 when 111
// [RL11] open window spans 12.5 to 100 percent of the period
// [RL12] violation clears the active-low fault flag; firmware sets it
// [RL13] counter and prescaler clear on reset and valid clear
// [RL14] counter clears on sleep entry and on wake-up
// [RL15] counter held clear when disabled or start-up timer runs
// [RL16] any write to either control register clears the counter; the code clears it only on writes with WB_SEL_I[0] set
// [RL17] prescale code 0 is 1:32, doubling to 2^23; reserved = min
// [RL18] window code 000 opens 12.5 percent, 111 opens all
// [RL19] firmware arms by reading control 0 before a windowed clear
// [RL20] time-out in sleep wakes the device and updates flags
// [RL21] leading closed part forbidden; one pulse per reset event
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
module wwdt_top
  import wwdt_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic [1:0]  DOG_MODE_CFG,
  input  wire logic [2:0]  CFG_CLK_SRC,
  input  wire logic [2:0]  CFG_OPEN_SPAN,
  input  wire logic [4:0]  CFG_PERIOD,
  input  wire logic        LOW_FREQ_TICK,
  input  wire logic        MID_FREQ_TICK,
  input  wire logic        DOG_CLEAR_INSTR,
  input  wire logic        SLEEP,
  input  wire logic        OSC_STARTUP_RUN,
  output logic             RESET_REQ,
  output logic             WAKE_REQ,
  output logic             SPAN_FAULT_FLAG_N,
  output logic             TIMEOUT_FLAG_N,
  output logic             POWERDOWN_FLAG_N
);

  // clamp reserved prescale codes to the minimum interval
  function automatic logic [4:0] ps_clamp(input logic [4:0] c);
    ps_clamp = (c > PS_MAX) ? 5'h00 : c;
  endfunction

  // address match for one register word
  function automatic logic adr_is(input logic [3:0] a,
                                  input logic [3:0] r);
    adr_is = (a == r);
  endfunction

  wwdt_bus_t          bus_r;
  wwdt_bus_t          bus_nxt;
  logic [4:0]         ps_r;
  logic               sw_dog_on_r;
  logic [2:0]         cs_r;
  logic [2:0]         wn_r;
  logic [CNT_W-1:0]   cnt_r;
  logic [3:0]         mid_div_r;
  logic               armed_r;
  logic               sleep_d_r;
  logic               span_n_r;
  logic               tmo_n_r;
  logic               pdn_n_r;
  logic               reset_req_r;
  logic               wake_r;
  logic [31:0]        dat_r;

  wire logic          req;
  wire logic          wr;
  wire logic          rd;
  wire logic          wr_c0;
  wire logic          wr_c1;
  wire logic          wr_st;
  wire logic          rd_c0;
  wire logic [4:0]    ps_eff;
  wire logic [4:0]    ps_code;
  wire logic [2:0]    cs_eff;
  wire logic [2:0]    wn_eff;
  wire logic          ps_soft;
  wire logic          cs_soft;
  wire logic          wn_soft;
  wire logic          mode_on;
  wire logic          mode_awk;
  wire logic          mode_sw;
  wire logic          active;
  wire logic          mid_tick;
  wire logic          tick;
  wire logic [23:0]   term;
  wire logic          expire;
  wire logic [2:0]    eighth;
  wire logic          windowed;
  wire logic          closed;
  wire logic          clr_cmd;
  wire logic          violation;
  wire logic          valid_clr;
  wire logic          sleep_in;
  wire logic          sleep_out;
  wire logic          hold_clr;
  wire logic [31:0]   rd_val;

  // bus decode, action taken at the ack edge
  assign req   = WB_CYC_I & WB_STB_I;
  assign wr    = req & (bus_r == WWDT_ACK) & WB_WE_I & WB_SEL_I[0];
  assign rd    = req & (bus_r == WWDT_ACK) & ~WB_WE_I;
  assign wr_c0 = wr & adr_is(WB_ADR_I, ADR_CTRL0);
  assign wr_c1 = wr & adr_is(WB_ADR_I, ADR_CTRL1);
  assign wr_st = wr & adr_is(WB_ADR_I, ADR_STAT);
  assign rd_c0 = rd & adr_is(WB_ADR_I, ADR_CTRL0);

  // software copies used only when config selects them
  assign ps_soft = (CFG_PERIOD == PS_SWSEL);
  assign cs_soft = (CFG_CLK_SRC == CS_SWSEL);
  assign wn_soft = (CFG_OPEN_SPAN == WN_SWSEL);
  assign ps_eff  = ps_soft ? ps_r : CFG_PERIOD; // [RL8]
  assign cs_eff  = cs_soft ? cs_r : CFG_CLK_SRC;
  assign wn_eff  = wn_soft ? wn_r : CFG_OPEN_SPAN; // [RL10]
  assign ps_code = ps_clamp(ps_eff); // [RL17]

  // operating mode decode
  assign mode_on  = (DOG_MODE_CFG == MODE_ON);
  assign mode_awk = (DOG_MODE_CFG == MODE_AWK);
  assign mode_sw  = (DOG_MODE_CFG == MODE_SW);
  assign active = mode_on |                 // [RL4]
                  (mode_awk & ~SLEEP) |     // [RL5]
                  (mode_sw & sw_dog_on_r);  // [RL6]
  // MODE_OFF falls through as inactive [RL3]

  // time base selection
  assign mid_tick = MID_FREQ_TICK & (mid_div_r == MID_DIV_TC);
  assign tick = (cs_eff == CS_MID) ? mid_tick : LOW_FREQ_TICK; // [RL2]

  // period of 2^(5+code) ticks [RL7]
  assign term   = (24'h000001 << (ps_code + 5'(PS_BASE_SH))) - 24'h000001;
  assign expire = active & tick & ({1'b0, cnt_r} == term); // [RL1]

  // period split in eighths; leading eighths are closed
  assign eighth   = 3'(cnt_r >> (ps_code + 5'(EIGHTH_SH)));
  assign windowed = (wn_eff != WN_FULL); // [RL18]
  assign closed   = windowed & (eighth < (WN_FULL - wn_eff)); // [RL11]

  // clear command checks
  assign clr_cmd   = DOG_CLEAR_INSTR & active;
  assign violation = clr_cmd & windowed & (closed | ~armed_r); // [RL9]
  assign valid_clr = clr_cmd & ~violation; // [RL13]

  // sleep edges
  assign sleep_in  = SLEEP & ~sleep_d_r;
  assign sleep_out = ~SLEEP & sleep_d_r;

  assign hold_clr = ~active | OSC_STARTUP_RUN | // [RL15]
                    sleep_in | sleep_out |      // [RL14]
                    wr_c0 | wr_c1 |             // [RL16]
                    valid_clr | violation | expire;

  // read mux
  assign rd_val =
    adr_is(WB_ADR_I, ADR_CTRL0) ?
      32'({ps_eff, sw_dog_on_r}) :
    adr_is(WB_ADR_I, ADR_CTRL1) ?
      32'({1'b0, cs_eff, 1'b0, wn_eff}) :
    adr_is(WB_ADR_I, ADR_STAT) ?
      32'({pdn_n_r, tmo_n_r, span_n_r}) :
    adr_is(WB_ADR_I, ADR_COUNT) ?
      32'(cnt_r) : 32'h00000000;

  // bus state
  always_comb begin
    case (bus_r)
      WWDT_IDLE: bus_nxt = req ? WWDT_ACK : WWDT_IDLE;
      WWDT_ACK:  bus_nxt = WWDT_IDLE;
      default:   bus_nxt = WWDT_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_r <= WWDT_IDLE;
      dat_r <= 32'h00000000;
    end else begin
      bus_r <= bus_nxt;
      dat_r <= rd_val;
    end
  end

  // control registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ps_r        <= PS_RESET; // [RL8]
      sw_dog_on_r <= 1'b0;
      cs_r        <= CS_RESET;
      wn_r        <= WN_RESET;
    end else begin
      if (wr_c0) begin
        sw_dog_on_r <= WB_DAT_I[C0_EN_BIT];
        if (ps_soft)
          ps_r <= WB_DAT_I[C0_PS_LSB +: 5];
      end
      if (wr_c1 && cs_soft)
        cs_r <= WB_DAT_I[C1_CS_LSB +: 3];
      if (wr_c1 && wn_soft)
        wn_r <= WB_DAT_I[C1_WN_LSB +: 3];
    end
  end

  // mid-frequency divide by sixteen
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)
      mid_div_r <= 4'h0;
    else if (hold_clr)
      mid_div_r <= 4'h0; // [RL13]
    else if (MID_FREQ_TICK)
      mid_div_r <= mid_div_r + 4'h1;
  end

  // combined prescaler and counter
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)
      cnt_r <= '0; // [RL13]
    else if (hold_clr)
      cnt_r <= '0;
    else if (tick)
      cnt_r <= cnt_r + CNT_W'(1);
  end

  // arming by a read of control 0
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)
      armed_r <= 1'b0;
    else if (rd_c0)
      armed_r <= 1'b1; // [RL19]
    else if (clr_cmd || !active)
      armed_r <= 1'b0;
  end

  // sleep level of the previous cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)
      sleep_d_r <= 1'b0;
    else
      sleep_d_r <= SLEEP;
  end

  // span fault flag; hardware clear beats software set
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)
      span_n_r <= 1'b1;
    else if (violation)
      span_n_r <= 1'b0; // [RL12]
    else if (wr_st && WB_DAT_I[ST_SPAN])
      span_n_r <= 1'b1; // [RL12]
  end

  // time-out flag; expiry beats a valid clear
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)
      tmo_n_r <= 1'b1;
    else if (expire)
      tmo_n_r <= 1'b0; // [RL20]
    else if (valid_clr)
      tmo_n_r <= 1'b1;
  end

  // power-down flag; sleep events beat a valid clear
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)
      pdn_n_r <= 1'b1;
    else if (sleep_in || (expire && SLEEP))
      pdn_n_r <= 1'b0; // [RL20]
    else if (valid_clr)
      pdn_n_r <= 1'b1;
  end

  // one pulse per event
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      reset_req_r <= 1'b0;
      wake_r      <= 1'b0;
    end else begin
      reset_req_r <= violation | (expire & ~SLEEP); // [RL21]
      wake_r      <= expire & SLEEP; // [RL20]
    end
  end

  assign WB_ACK_O          = req & (bus_r == WWDT_ACK);
  assign WB_DAT_O          = dat_r;
  assign RESET_REQ         = reset_req_r; // [RL1]
  assign WAKE_REQ          = wake_r;
  assign SPAN_FAULT_FLAG_N = span_n_r;
  assign TIMEOUT_FLAG_N    = tmo_n_r;
  assign POWERDOWN_FLAG_N  = pdn_n_r;

endmodule

// *** bench/wwdt_monitor.sv ***
// Purpose: port assertions for wwdt_top
// Assumes: one clock domain, async low reset
// Notes:   bound to every wwdt_top below
`timescale 1ns/10ps
module wwdt_monitor
  import wwdt_pkg::*;
(
  input wire logic       MCLK,
  input wire logic       RST_N,
  input wire logic       WB_CYC_I,
  input wire logic       WB_STB_I,
  input wire logic       WB_ACK_O,
  input wire logic [1:0] DOG_MODE_CFG,
  input wire logic       LOW_FREQ_TICK,
  input wire logic       MID_FREQ_TICK,
  input wire logic       DOG_CLEAR_INSTR,
  input wire logic       SLEEP,
  input wire logic       OSC_STARTUP_RUN,
  input wire logic       RESET_REQ,
  input wire logic       WAKE_REQ,
  input wire logic       SPAN_FAULT_FLAG_N,
  input wire logic       TIMEOUT_FLAG_N,
  input wire logic       POWERDOWN_FLAG_N
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  wire req = WB_CYC_I & WB_STB_I;
  wire tck = LOW_FREQ_TICK | MID_FREQ_TICK;
  property p_ack_lat; $rose(req) |=> WB_ACK_O; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");
  property p_pulse; RESET_REQ |=> !RESET_REQ; endproperty
  a_pulse: assert property (p_pulse) else $error("reset long");
  property p_off;
    $past(DOG_MODE_CFG) == MODE_OFF |-> !(RESET_REQ | WAKE_REQ);
  endproperty
  a_off: assert property (p_off) else $error("request when off");
  property p_tmo;
    RESET_REQ && !$past(DOG_CLEAR_INSTR)
      |-> $past(tck) ##[0:1] !TIMEOUT_FLAG_N;
  endproperty
  a_tmo: assert property (p_tmo) else $error("bad time-out");
  property p_span;
    RESET_REQ && $past(DOG_CLEAR_INSTR) |-> ##[0:1] !SPAN_FAULT_FLAG_N;
  endproperty
  a_span: assert property (p_span) else $error("fault flag");
  property p_wake;
    WAKE_REQ |-> $past(SLEEP) && !RESET_REQ ##1 !WAKE_REQ;
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  property p_wflg;
    WAKE_REQ |-> ##[0:1] (!TIMEOUT_FLAG_N && !POWERDOWN_FLAG_N);
  endproperty
  a_wflg: assert property (p_wflg) else $error("wake flags");
  property p_ost;
    $past(OSC_STARTUP_RUN, 2) && $past(OSC_STARTUP_RUN)
      && !$past(DOG_CLEAR_INSTR) |-> !(RESET_REQ | WAKE_REQ);
  endproperty
  a_ost: assert property (p_ost) else $error("count in start-up");
  c_wake: cover property (WAKE_REQ);
  c_viol: cover property (RESET_REQ && $past(DOG_CLEAR_INSTR));
  c_tmo: cover property (RESET_REQ && !$past(DOG_CLEAR_INSTR));
endmodule
bind wwdt_top wwdt_monitor u_mon (.MCLK, .RST_N, .WB_CYC_I, .WB_STB_I,
  .WB_ACK_O, .DOG_MODE_CFG, .LOW_FREQ_TICK, .MID_FREQ_TICK,
  .DOG_CLEAR_INSTR, .SLEEP, .OSC_STARTUP_RUN, .RESET_REQ, .WAKE_REQ,
  .SPAN_FAULT_FLAG_N, .TIMEOUT_FLAG_N, .POWERDOWN_FLAG_N);

// *** bench/wwdt_cpu_model.sv ***
// Purpose: cpu and oscillator side of the watchdog
// Assumes: ticks and clear are one-cycle pulses
// Notes:   low osc every 16 cycles, mid osc every 2
`timescale 1ns/10ps
module wwdt_cpu_model (
  input  wire logic mclk,
  input  wire logic reset_req,
  input  wire logic wake_req,
  output logic      lf_tick,
  output logic      mf_tick,
  output logic      clr
);
  logic [3:0] div_r = 4'h0;
  int         n_rst = 0;
  int         n_wake = 0;
  initial clr = 1'b0;
  assign lf_tick = (div_r == 4'hF);
  assign mf_tick = div_r[0];
  always @(posedge mclk) begin
    div_r <= div_r + 4'h1;
    n_rst <= n_rst + int'(reset_req);
    n_wake <= n_wake + int'(wake_req);
  end
  task automatic pulse_clear;
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
  endtask
endmodule

// *** bench/wwdt_top_tb.sv ***
// Purpose: self-checking bench for wwdt_top
// Assumes: period code 0, 32 ticks of 16 cycles
// Notes:   mode table first, window and start-up after
`timescale 1ns/10ps
`define CHK(a, e) \
  begin \
    checks_done++; \
    if ((a) !== (e)) begin \
      n_errors++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end
module wwdt_top_tb
  import wwdt_pkg::*;
;
  typedef struct {
    logic [1:0] m;
    logic       s;
    logic       e;
    logic [2:0] c;
    int         r;
    int         w;
  } wwdt_row_t;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        slp = 1'b0;
  logic        osc = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [1:0]  mode = 2'h0;
  logic [2:0]  cs = 3'h0;
  logic [2:0]  span = 3'h7;
  logic [4:0]  per = 5'h00;
  logic [31:0] rd, q;
  logic        ack, rq, wk, clr, lf, mf, sf_n, to_n, pd_n;
  int          n_errors = 0;
  int          checks_done = 0;
  int          r0, w0;
  logic [3:0]  ra [4] = '{ADR_CTRL0, ADR_CTRL1, ADR_STAT, 4'h2};
  logic [31:0] rv [4] = '{32'h16, 32'h07, 32'h07, 32'h00};
  wwdt_row_t   rows [9] = '{'{MODE_OFF, 0, 1, 0, 0, 0},
    '{MODE_SW, 0, 1, 0, 2, 0}, '{MODE_SW, 0, 0, 0, 0, 0},
    '{MODE_SW, 1, 1, 0, 0, 2}, '{MODE_AWK, 0, 0, 0, 2, 0},
    '{MODE_AWK, 1, 0, 0, 0, 0}, '{MODE_ON, 1, 0, 0, 0, 2},
    '{MODE_ON, 0, 0, 0, 2, 0}, '{MODE_ON, 0, 0, CS_MID, 1, 0}};
  wwdt_top dut (.MCLK(mclk), .RST_N(rst_n), .WB_ADR_I(adr),
    .WB_DAT_I(dat), .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_DAT_O(rd), .WB_ACK_O(ack), .DOG_MODE_CFG(mode),
    .CFG_CLK_SRC(cs), .CFG_OPEN_SPAN(span), .CFG_PERIOD(per),
    .LOW_FREQ_TICK(lf), .MID_FREQ_TICK(mf), .DOG_CLEAR_INSTR(clr),
    .SLEEP(slp), .OSC_STARTUP_RUN(osc), .RESET_REQ(rq), .WAKE_REQ(wk),
    .SPAN_FAULT_FLAG_N(sf_n), .TIMEOUT_FLAG_N(to_n),
    .POWERDOWN_FLAG_N(pd_n));
  wwdt_cpu_model cpu (.mclk(mclk), .reset_req(rq), .wake_req(wk),
    .lf_tick(lf), .mf_tick(mf), .clr(clr));
  always #25 mclk = ~mclk;
  task automatic rst(input logic [1:0] m, input logic s,
    input logic [2:0] c, input logic [2:0] w, input logic [4:0] p,
    input logic o);
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    {mode, slp, cs, span, per, osc} <= {m, s, c, w, p, o};
    @(posedge mclk);
    rst_n <= 1'b1;
  endtask
  task automatic wb(input logic [3:0] a, input logic w,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {adr, we, dat, cyc, stb} <= {a, w, d, 2'b11};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rd;
    {we, cyc, stb} <= 3'b000;
    if (n >= 50) n_errors++;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic summarize;
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    n_errors++;
    summarize();
  end
  initial begin
    for (int i = 0; i < 9; i++) begin
      rst(rows[i].m, rows[i].s, rows[i].c, WN_FULL, 5'h00, 1'b0);
      wb(ADR_CTRL0, 1'b1, {31'h0, rows[i].e});
      r0 = cpu.n_rst;
      w0 = cpu.n_wake;
      wt(1100);
      `CHK(cpu.n_rst - r0, rows[i].r)
      `CHK(cpu.n_wake - w0, rows[i].w)
      `CHK(to_n, (rows[i].r + rows[i].w) == 0)
      `CHK(pd_n, !rows[i].s)
    end
    rst(MODE_ON, 1'b0, CS_SWSEL, WN_SWSEL, PS_SWSEL, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wb(ra[i], 1'b0, 32'h0);
      `CHK(q, rv[i])
    end
    wb(ADR_CTRL1, 1'b1, 32'h02);
    wb(ADR_CTRL1, 1'b0, 32'h0);
    `CHK(q, 32'h02)
    wb(ADR_CTRL0, 1'b1, 32'h26);
    r0 = cpu.n_rst;
    wt(600);
    `CHK(cpu.n_rst - r0, 1)
    rst(MODE_ON, 1'b0, CS_RESET, 3'h0, 5'h00, 1'b0);
    r0 = cpu.n_rst;
    wb(ADR_CTRL0, 1'b0, 32'h0);
    cpu.pulse_clear();
    wt(3);
    `CHK(cpu.n_rst - r0, 1)
    `CHK(sf_n, 1'b0)
    wb(ADR_STAT, 1'b1, 32'h1);
    wt(1);
    `CHK(sf_n, 1'b1)
    wb(ADR_CTRL1, 1'b1, 32'h0);
    r0 = cpu.n_rst;
    wt(470);
    cpu.pulse_clear();
    wt(3);
    `CHK(cpu.n_rst - r0, 1)
    wb(ADR_CTRL1, 1'b1, 32'h0);
    r0 = cpu.n_rst;
    wt(460);
    wb(ADR_CTRL0, 1'b0, 32'h0);
    cpu.pulse_clear();
    wt(300);
    `CHK(cpu.n_rst - r0, 0)
    rst(MODE_ON, 1'b0, CS_RESET, WN_FULL, 5'h00, 1'b1);
    r0 = cpu.n_rst;
    wt(600);
    `CHK(cpu.n_rst - r0, 0)
    wb(ADR_COUNT, 1'b0, 32'h0);
    `CHK(q, 32'h0)
    osc <= 1'b0;
    wt(300);
    wb(ADR_COUNT, 1'b0, 32'h0);
    `CHK(q > 32'h10, 1'b1)
    wb(ADR_CTRL1, 1'b1, 32'h0);
    wb(ADR_COUNT, 1'b0, 32'h0);
    `CHK(q < 32'h2, 1'b1)
    summarize();
  end
endmodule
